// >>> design/dacl_pkg.sv
// Functional notes
// - Latch held high freezes outputs against writes.
// - Latch going low transfers volatile values out.
// - Latch low: writes reach outputs at once.
// - Latch covers wiper, reference, power-down, gain.
// - Shared latch pin updates both channels together.
// - Reference pin input if external, output if bandgap.
// - Supply reference disconnects the reference pin.
// - External reference offers buffered and unbuffered.
// - Full scale follows reference; gain 1X or 2X.
// - Power-down selects 1k, 100k pull-down or open.
// - Commands accepted only while chip select active.
// - Data input writes registers; data output reads them.
// - Rising supply loads default wiper and configuration.
// - Default is mid-scale or stored nonvolatile value.
// - Power-on reset sets power-on status bit.
// - Serial port refuses commands until delay expires.
// - Power-on reset forces address pointer to 00h.
// - Brown-out disables serial port and nonvolatile writes.
// - Brown-out forces power-down 11, analog off.
// - Brown-out clears wiper, reference and gain bits.
// - New nonvolatile values load only at power-on.
// - Unprogrammed nonvolatile parts load factory defaults.
package dacl_pkg;

  // ****************************************************************
  // Register addresses, frame layout and encodings.
  // ****************************************************************
  localparam int WIPER_W = 12;
  localparam logic [4:0] ADDR_WIPER0 = 5'h00;
  localparam logic [4:0] ADDR_WIPER1 = 5'h01;
  localparam logic [4:0] ADDR_VREF = 5'h08;
  localparam logic [4:0] ADDR_PD = 5'h09;
  localparam logic [4:0] ADDR_GAIN = 5'h0a;
  localparam logic [4:0] ADDR_RESET = 5'h00;
  localparam logic [1:0] CMD_WR = 2'h0;
  localparam logic [1:0] CMD_RD = 2'h3;
  localparam logic [4:0] FRAME_BITS = 5'h18;
  localparam logic [4:0] HDR_BITS = 5'h08;
  localparam int GAIN_POS0 = 8;
  localparam int GAIN_POS1 = 9;
  localparam int POR_POS = 7;
  localparam logic [1:0] VR_SUPPLY = 2'h0;
  localparam logic [1:0] VR_BANDGAP = 2'h1;
  localparam logic [1:0] VR_EXT_UNBUF = 2'h2;
  localparam logic [1:0] VR_EXT_BUF = 2'h3;
  localparam logic [1:0] PD_NORMAL = 2'h0;
  localparam logic [1:0] PD_1K = 2'h1;
  localparam logic [1:0] PD_100K = 2'h2;
  localparam logic [1:0] PD_OPEN = 2'h3;

  // ****************************************************************
  // Timing.
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int RST_DELAY_NS = 10000;
  localparam logic [15:0] RST_DELAY_CYC =
    16'((RST_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ****************************************************************
  // Carriers.
  // ****************************************************************
  typedef struct packed {
    logic [WIPER_W-1:0] wiper;
    logic [1:0] vref;
    logic [1:0] pd;
    logic gain;
  } dacl_chan_s;

  typedef struct packed {
    logic ref_pin_out;
    logic ref_pin_connect;
    logic ref_buffer_on;
    logic ref_from_supply;
    logic gain_2x;
    logic pull_1k;
    logic pull_100k;
    logic amp_on;
  } dacl_ana_s;

  localparam dacl_chan_s CHAN_BOR = '{wiper: '0, vref: VR_SUPPLY,
                                       pd: PD_OPEN, gain: 1'b0};

endpackage : dacl_pkg

// >>> design/dacl_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module dacl_ctrl
#(
  parameter int RES_BITS = 12,
  parameter bit DUAL = 1'b1,
  parameter bit SHARED_LATCH = 1'b1,
  parameter bit NONVOLATILE = 1'b0
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic supply_ok,
  input wire logic update_latch_and_program_pin,
  input wire logic output_update_latch1,
  input wire logic nv_programmed,
  input wire dacl_pkg::dacl_chan_s nv_ch0,
  input wire dacl_pkg::dacl_chan_s nv_ch1,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  output var dacl_pkg::dacl_ana_s ana0,
  output var dacl_pkg::dacl_ana_s ana1,
  output logic [dacl_pkg::WIPER_W-1:0] dac_code0,
  output logic [dacl_pkg::WIPER_W-1:0] dac_code1,
  output logic por_status,
  output logic port_ready,
  output logic mtp_write_enable,
  output logic analog_enable,
  output logic [4:0] mem_addr_ptr
);

  // ****************************************************************
  // Constants and types.
  // ****************************************************************
  localparam logic [dacl_pkg::WIPER_W-1:0] MID_CODE =
    dacl_pkg::WIPER_W'((1 << (RES_BITS - 1)) - 1);
  localparam logic [dacl_pkg::WIPER_W-1:0] CODE_MASK =
    dacl_pkg::WIPER_W'((1 << RES_BITS) - 1);

  typedef enum logic [1:0] {ST_OFF, ST_DELAY, ST_RUN} dacl_st_e;

  // Maps one channel's latched settings onto its analog controls.
  function automatic dacl_pkg::dacl_ana_s ana_of(dacl_pkg::dacl_chan_s c);
    dacl_pkg::dacl_ana_s a;
    a.ref_pin_out = (c.vref == dacl_pkg::VR_BANDGAP);
    a.ref_pin_connect = (c.vref != dacl_pkg::VR_SUPPLY);
    a.ref_buffer_on = (c.vref == dacl_pkg::VR_EXT_BUF);
    a.ref_from_supply = (c.vref == dacl_pkg::VR_SUPPLY);
    a.gain_2x = c.gain && (c.vref != dacl_pkg::VR_SUPPLY);
    a.pull_1k = (c.pd == dacl_pkg::PD_1K);
    a.pull_100k = (c.pd == dacl_pkg::PD_100K);
    a.amp_on = (c.pd == dacl_pkg::PD_NORMAL);
    return a;
  endfunction : ana_of

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  logic sup_s1_r, sup_s2_r;
  logic lat0_s1_r, lat0_s2_r, lat1_s1_r, lat1_s2_r;
  logic cs_s1_r, cs_s2_r;
  logic tog_s1_r, tog_s2_r, tog_s3_r;
  dacl_st_e st_r, st_nxt;
  logic [15:0] tmr_r, tmr_nxt;
  logic por_r, por_nxt;
  logic [4:0] addr_r, addr_nxt;
  logic taint_r, taint_nxt;
  logic ready_r, ready_nxt;
  logic aen_r, aen_nxt;
  dacl_pkg::dacl_chan_s vol0_r, vol0_nxt, vol1_r, vol1_nxt;
  dacl_pkg::dacl_chan_s out0_r, out0_nxt, out1_r, out1_nxt;
  dacl_pkg::dacl_ana_s ana0_r, ana0_nxt, ana1_r, ana1_nxt;
  dacl_pkg::dacl_chan_s def0, def1;
  logic lat1_held;
  logic frame_done;
  logic commit;

  // Serial clock domain.
  logic [4:0] cnt_r, cnt_nxt;
  logic [23:0] sh_r, sh_nxt;
  logic [23:0] word_r, word_nxt;
  logic tog_r, tog_nxt;
  logic rdy_k1_r, rdy_k2_r;
  logic [15:0] tx_r, tx_nxt;
  logic oe_r, oe_nxt;
  logic [15:0] rd_data;

  // ****************************************************************
  // Synchronisers into the core clock.
  // ****************************************************************
  // Supply monitor, latch pins, chip select and the frame toggle.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      sup_s1_r <= 1'b0;
      sup_s2_r <= 1'b0;
      lat0_s1_r <= 1'b1;
      lat0_s2_r <= 1'b1;
      lat1_s1_r <= 1'b1;
      lat1_s2_r <= 1'b1;
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      tog_s1_r <= 1'b0;
      tog_s2_r <= 1'b0;
      tog_s3_r <= 1'b0;
    end
    else
    begin
      sup_s1_r <= supply_ok;
      sup_s2_r <= sup_s1_r;
      lat0_s1_r <= update_latch_and_program_pin;
      lat0_s2_r <= lat0_s1_r;
      lat1_s1_r <= output_update_latch1;
      lat1_s2_r <= lat1_s1_r;
      cs_s1_r <= spi_cs_n;
      cs_s2_r <= cs_s1_r;
      tog_s1_r <= tog_r;
      tog_s2_r <= tog_s1_r;
      tog_s3_r <= tog_s2_r;
    end
  end

  // A finished write frame shows as an edge on the synchronised toggle.
  assign frame_done = tog_s2_r ^ tog_s3_r;
  // Only frames seen entirely in the running state are committed.
  assign commit = frame_done && (st_r == ST_RUN) && !taint_r;

  // Power-on values: stored ones only if present and programmed.
  always_comb
  begin
    def0 = '{wiper: MID_CODE, vref: dacl_pkg::VR_SUPPLY,
             pd: dacl_pkg::PD_NORMAL, gain: 1'b0};
    def1 = def0;
    if (NONVOLATILE && nv_programmed)
    begin
      def0 = nv_ch0;
      def1 = nv_ch1;
      def0.wiper = nv_ch0.wiper & CODE_MASK;
      def1.wiper = nv_ch1.wiper & CODE_MASK;
    end
  end

  // ****************************************************************
  // Supply sequencing and volatile registers.
  // ****************************************************************
  // Next state of the reset sequencer and of the volatile registers.
  always_comb
  begin
    st_nxt = st_r;
    tmr_nxt = tmr_r;
    por_nxt = por_r;
    addr_nxt = addr_r;
    vol0_nxt = vol0_r;
    vol1_nxt = vol1_r;
    taint_nxt = taint_r;
    unique case (st_r)
      ST_OFF:
      begin
        if (sup_s2_r)
        begin
          st_nxt = ST_DELAY;
          tmr_nxt = dacl_pkg::RST_DELAY_CYC;
          vol0_nxt = def0;
          vol1_nxt = def1;
          por_nxt = 1'b1;
          addr_nxt = dacl_pkg::ADDR_RESET;
        end
      end
      ST_DELAY:
      begin
        tmr_nxt = 16'(tmr_r - 16'h0001);
        if (tmr_r == 16'h0001)
        begin
          st_nxt = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (commit && (word_r[18:17] == dacl_pkg::CMD_WR))
        begin
          addr_nxt = word_r[23:19];
          unique case (word_r[23:19])
            dacl_pkg::ADDR_WIPER0:
            begin
              vol0_nxt.wiper = word_r[dacl_pkg::WIPER_W-1:0] & CODE_MASK;
            end
            dacl_pkg::ADDR_WIPER1:
            begin
              if (DUAL)
              begin
                vol1_nxt.wiper = word_r[dacl_pkg::WIPER_W-1:0] & CODE_MASK;
              end
            end
            dacl_pkg::ADDR_VREF:
            begin
              vol0_nxt.vref = word_r[1:0];
              vol1_nxt.vref = word_r[3:2];
            end
            dacl_pkg::ADDR_PD:
            begin
              vol0_nxt.pd = word_r[1:0];
              vol1_nxt.pd = word_r[3:2];
            end
            dacl_pkg::ADDR_GAIN:
            begin
              vol0_nxt.gain = word_r[dacl_pkg::GAIN_POS0];
              vol1_nxt.gain = word_r[dacl_pkg::GAIN_POS1];
            end
            default:
            begin
              addr_nxt = addr_r;
            end
          endcase
        end
      end
    endcase
    // Falling supply overrides the state, timer and volatile registers.
    if (!sup_s2_r)
    begin
      st_nxt = ST_OFF;
      tmr_nxt = '0;
      vol0_nxt = dacl_pkg::CHAN_BOR;
      vol1_nxt = dacl_pkg::CHAN_BOR;
    end
    // A frame overlapping a non-running state stays tainted until idle.
    if (!cs_s2_r && (st_r != ST_RUN))
    begin
      taint_nxt = 1'b1;
    end
    else if (cs_s2_r && !frame_done)
    begin
      taint_nxt = 1'b0;
    end
    ready_nxt = (st_nxt == ST_RUN);
    aen_nxt = (st_nxt != ST_OFF);
  end

  // Registers of the sequencer and volatile state.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      st_r <= ST_OFF;
      tmr_r <= '0;
      por_r <= 1'b0;
      addr_r <= dacl_pkg::ADDR_RESET;
      vol0_r <= dacl_pkg::CHAN_BOR;
      vol1_r <= dacl_pkg::CHAN_BOR;
      taint_r <= 1'b0;
      ready_r <= 1'b0;
      aen_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      por_r <= por_nxt;
      addr_r <= addr_nxt;
      vol0_r <= vol0_nxt;
      vol1_r <= vol1_nxt;
      taint_r <= taint_nxt;
      ready_r <= ready_nxt;
      aen_r <= aen_nxt;
    end
  end

  // ****************************************************************
  // Output update latch.
  // ****************************************************************
  // Channel one follows the shared pin unless it has its own.
  assign lat1_held = SHARED_LATCH ? lat0_s2_r : lat1_s2_r;

  // Outputs track volatile values while the latch is low.
  always_comb
  begin
    out0_nxt = out0_r;
    out1_nxt = out1_r;
    if (st_r == ST_OFF)
    begin
      out0_nxt = dacl_pkg::CHAN_BOR;
      out1_nxt = dacl_pkg::CHAN_BOR;
    end
    else
    begin
      if (!lat0_s2_r)
      begin
        out0_nxt = vol0_r;
      end
      if (!lat1_held)
      begin
        out1_nxt = vol1_r;
      end
    end
    if (!DUAL)
    begin
      out1_nxt = dacl_pkg::CHAN_BOR;
    end
    ana0_nxt = ana_of(out0_nxt);
    ana1_nxt = ana_of(out1_nxt);
  end

  // Registers of the latched outputs and analog controls.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      out0_r <= dacl_pkg::CHAN_BOR;
      out1_r <= dacl_pkg::CHAN_BOR;
      ana0_r <= ana_of(dacl_pkg::CHAN_BOR);
      ana1_r <= ana_of(dacl_pkg::CHAN_BOR);
    end
    else
    begin
      out0_r <= out0_nxt;
      out1_r <= out1_nxt;
      ana0_r <= ana0_nxt;
      ana1_r <= ana1_nxt;
    end
  end

  assign ana0 = ana0_r;
  assign ana1 = ana1_r;
  assign dac_code0 = out0_r.wiper;
  assign dac_code1 = out1_r.wiper;
  assign por_status = por_r;
  assign port_ready = ready_r;
  assign mtp_write_enable = ready_r;
  assign analog_enable = aen_r;
  assign mem_addr_ptr = addr_r;

  // ****************************************************************
  // Serial port, clocked by the host's serial clock.
  // ****************************************************************
  // Shift in header and data; the word closes on the last bit.
  always_comb
  begin
    cnt_nxt = cnt_r;
    sh_nxt = {sh_r[22:0], spi_sdi};
    word_nxt = word_r;
    tog_nxt = tog_r;
    if (cnt_r != dacl_pkg::FRAME_BITS)
    begin
      cnt_nxt = 5'(cnt_r + 5'h01);
      if (cnt_r == 5'(dacl_pkg::FRAME_BITS - 5'h01))
      begin
        word_nxt = sh_nxt;
        // Command bits sit one place lower before the last bit shifts in.
        tog_nxt = tog_r ^ (sh_r[17:16] == dacl_pkg::CMD_WR);
      end
    end
  end

  // The bit counter clears whenever chip select is released.
  always_ff @(posedge spi_sck or posedge spi_cs_n)
  begin
    if (spi_cs_n)
    begin
      cnt_r <= '0;
      rdy_k1_r <= 1'b0;
      rdy_k2_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      rdy_k1_r <= ready_r;
      rdy_k2_r <= rdy_k1_r;
    end
  end

  // The received word and its toggle survive between frames.
  always_ff @(posedge spi_sck or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh_r <= '0;
      word_r <= '0;
      tog_r <= 1'b0;
    end
    else
    begin
      sh_r <= sh_nxt;
      word_r <= word_nxt;
      tog_r <= tog_nxt;
    end
  end

  // Read-back image of the volatile registers.
  always_comb
  begin
    rd_data = '0;
    unique case (sh_r[7:3])
      dacl_pkg::ADDR_WIPER0: rd_data[dacl_pkg::WIPER_W-1:0] = vol0_r.wiper;
      dacl_pkg::ADDR_WIPER1: rd_data[dacl_pkg::WIPER_W-1:0] = vol1_r.wiper;
      dacl_pkg::ADDR_VREF: rd_data[3:0] = {vol1_r.vref, vol0_r.vref};
      dacl_pkg::ADDR_PD: rd_data[3:0] = {vol1_r.pd, vol0_r.pd};
      dacl_pkg::ADDR_GAIN:
      begin
        rd_data[dacl_pkg::GAIN_POS0] = vol0_r.gain;
        rd_data[dacl_pkg::GAIN_POS1] = vol1_r.gain;
        rd_data[dacl_pkg::POR_POS] = por_r;
      end
      default: rd_data = '0;
    endcase
  end

  // Read data is loaded after the header and shifted out MSB first.
  always_comb
  begin
    tx_nxt = {tx_r[14:0], 1'b0};
    oe_nxt = oe_r;
    if ((cnt_r == dacl_pkg::HDR_BITS) && (sh_r[2:1] == dacl_pkg::CMD_RD)
        && rdy_k2_r)
    begin
      tx_nxt = rd_data;
      oe_nxt = 1'b1;
    end
  end

  // Output side of the serial port changes on the falling edge.
  always_ff @(negedge spi_sck or posedge spi_cs_n)
  begin
    if (spi_cs_n)
    begin
      tx_r <= '0;
      oe_r <= 1'b0;
    end
    else
    begin
      tx_r <= tx_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign spi_sdo = tx_r[15];
  assign spi_sdo_oe = oe_r;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  property p_hold;
    (lat0_s2_r && st_r != ST_OFF) |=> (out0_r == $past(out0_r));
  endproperty
  a_hold: assert property (p_hold)
    else $error("Output changed while latch was held.");

  property p_follow;
    (!lat0_s2_r && st_r != ST_OFF) |=> (out0_r == $past(vol0_r));
  endproperty
  a_follow: assert property (p_follow)
    else $error("Output did not follow volatile value with latch low.");

  property p_shared;
    (SHARED_LATCH && DUAL && !lat0_s2_r && st_r != ST_OFF)
      |=> (out1_r == $past(vol1_r));
  endproperty
  a_shared: assert property (p_shared)
    else $error("Second channel missed the shared latch.");

  property p_refpin;
    (ana0_r.ref_pin_out == (out0_r.vref == dacl_pkg::VR_BANDGAP))
      && (ana0_r.ref_pin_connect == (out0_r.vref != dacl_pkg::VR_SUPPLY));
  endproperty
  a_refpin: assert property (p_refpin)
    else $error("Reference pin direction wrong.");

  property p_gain;
    ana0_r.gain_2x |-> (out0_r.gain && out0_r.vref != dacl_pkg::VR_SUPPLY);
  endproperty
  a_gain: assert property (p_gain)
    else $error("Gain 2X with supply reference.");

  property p_pull;
    (out0_r.pd == dacl_pkg::PD_OPEN) |->
      !(ana0_r.pull_1k || ana0_r.pull_100k || ana0_r.amp_on);
  endproperty
  a_pull: assert property (p_pull)
    else $error("Open power-down still loads the output.");

  property p_delay;
    (st_r == ST_OFF && sup_s2_r) |=> (!port_ready && por_status
      && mem_addr_ptr == dacl_pkg::ADDR_RESET) [*8];
  endproperty
  a_delay: assert property (p_delay)
    else $error("Port ready too early after power-on.");

  property p_por;
    (st_r == ST_OFF && sup_s2_r) |=> (vol0_r == $past(def0));
  endproperty
  a_por: assert property (p_por)
    else $error("Defaults not loaded at power-on.");

  property p_bor;
    $fell(sup_s2_r) |=> (vol0_r == dacl_pkg::CHAN_BOR && !port_ready
      && !mtp_write_enable) ##1 (out0_r.pd == dacl_pkg::PD_OPEN
      && !analog_enable);
  endproperty
  a_bor: assert property (p_bor)
    else $error("Brown-out state not applied.");

  property p_taint;
    (frame_done && taint_r && sup_s2_r && st_r != ST_OFF)
      |=> (vol0_r == $past(vol0_r) && vol1_r == $past(vol1_r));
  endproperty
  a_taint: assert property (p_taint)
    else $error("Tainted frame was committed.");

  c_run: cover property (st_r == ST_DELAY ##1 st_r == ST_RUN);
  c_held_write: cover property (lat0_s2_r && commit);
  c_bor: cover property (st_r == ST_RUN ##1 st_r == ST_OFF);
  c_taint: cover property (frame_done && taint_r);

endmodule : dacl_ctrl
`default_nettype wire

// >>> tb/dacl_spi_host.sv
`timescale 1ns/100ps
`default_nettype none
module dacl_spi_host
(
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_sdi,
  input wire logic spi_sdo
);
  // ****************************************************************
  // Serial host that owns the link clock.
  // ****************************************************************
  localparam real HALF = 62.5;
  logic [15:0] rd_word;

  // Idle state: deselected, clock parked low, no frame running.
  initial
  begin
    spi_cs_n = 1'b1;
    spi_sck = 1'b0;
    spi_sdi = 1'b0;
    rd_word = '0;
  end

  // Sends one 24-bit frame MSB first and gathers the answer bits.
  task automatic xfer(input logic [4:0] addr, input logic [1:0] cmd,
                      input logic [15:0] data);
    logic [23:0] word;
    word = {addr, cmd, 1'b0, data};
    #13;
    spi_cs_n = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      spi_sdi = word[i];
      #HALF;
      spi_sck = 1'b1;
      if (i < 16)
        rd_word[i] = spi_sdo;
      #HALF;
      spi_sck = 1'b0;
    end
    #HALF;
    spi_cs_n = 1'b1;
    spi_sdi = ~spi_sdi;
    #250;
  endtask : xfer
endmodule : dacl_spi_host
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  // ****************************************************************
  // Signals, notes and instances.
  // ****************************************************************
  typedef struct packed {logic [2:0] sel; logic [31:0] exp;} dacl_note_s;
  logic core_clk, rst_n, supply_ok, latch_pin, latch1, nv_programmed;
  dacl_pkg::dacl_chan_s nv_ch0, nv_ch1;
  dacl_pkg::dacl_ana_s ana0, ana1;
  logic spi_sck, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe;
  logic [11:0] dac_code0, dac_code1, w0, w1, n0, n1;
  logic por_status, port_ready, mtp_write_enable, analog_enable;
  logic [4:0] mem_addr_ptr;
  logic [1:0] vr0, vr1;
  logic g0, g1;
  int seed, failures, check_count;
  dacl_note_s notes[$];
  dacl_note_s cur;
  event look;

  dacl_ctrl u_dut (.core_clk(core_clk), .rst_n(rst_n),
    .supply_ok(supply_ok), .update_latch_and_program_pin(latch_pin),
    .output_update_latch1(latch1), .nv_programmed(nv_programmed),
    .nv_ch0(nv_ch0), .nv_ch1(nv_ch1), .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
    .spi_sdo_oe(spi_sdo_oe), .ana0(ana0), .ana1(ana1),
    .dac_code0(dac_code0), .dac_code1(dac_code1),
    .por_status(por_status), .port_ready(port_ready),
    .mtp_write_enable(mtp_write_enable), .analog_enable(analog_enable),
    .mem_addr_ptr(mem_addr_ptr));

  dacl_spi_host u_host (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
    .spi_sdi(spi_sdi), .spi_sdo(spi_sdo));

  // Core clock at 20 MHz.
  initial core_clk = 1'b0;
  always #25 core_clk = ~core_clk;

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  function automatic logic [31:0] view(input logic [2:0] sel);
    case (sel)
      3'h0: return {8'h00, dac_code1, dac_code0};
      3'h1: return {16'h0000, ana1, ana0};
      3'h2: return {28'h0, analog_enable, mtp_write_enable, port_ready,
                    por_status};
      3'h3: return {16'h0000, u_host.rd_word};
      3'h4: return {31'h0, spi_sdo_oe};
      default: return {27'h0, mem_addr_ptr};
    endcase
  endfunction : view

  // Expected analog controls for one channel's settings.
  function automatic dacl_pkg::dacl_ana_s ana_exp(input logic [1:0] vr,
                                                  input logic [1:0] pd,
                                                  input logic g);
    ana_exp.ref_pin_out = (vr == dacl_pkg::VR_BANDGAP);
    ana_exp.ref_pin_connect = (vr != dacl_pkg::VR_SUPPLY);
    ana_exp.ref_buffer_on = (vr == dacl_pkg::VR_EXT_BUF);
    ana_exp.ref_from_supply = (vr == dacl_pkg::VR_SUPPLY);
    ana_exp.gain_2x = g && (vr != dacl_pkg::VR_SUPPLY);
    ana_exp.pull_1k = (pd == dacl_pkg::PD_1K);
    ana_exp.pull_100k = (pd == dacl_pkg::PD_100K);
    ana_exp.amp_on = (pd == dacl_pkg::PD_NORMAL);
  endfunction : ana_exp

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  task automatic check_val(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check_val

  task automatic note(input logic [2:0] sel, input logic [31:0] exp);
    notes.push_back('{sel: sel, exp: exp});
    -> look;
  endtask : note

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    u_host.xfer(a, dacl_pkg::CMD_WR, d);
    cyc(4);
  endtask : wr

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  // Waits, with a bound, for the serial port to open.
  task automatic wait_ready();
    int n;
    n = 0;
    while (port_ready !== 1'b1 && n < 400)
    begin
      cyc(1);
      n++;
    end
    if (n >= 400)
    begin
      failures++;
      give_verdict();
    end
  endtask : wait_ready

  // Watcher: compares every pending note with the outputs it names.
  always @(look)
  begin
    while (notes.size() > 0)
    begin
      cur = notes.pop_front();
      check_val(view(cur.sel), cur.exp);
    end
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial
  begin
    seed = 32'h0c70a900;
    failures = 0;
    check_count = 0;
    rst_n = 1'b0;
    supply_ok = 1'b0;
    latch_pin = 1'b0;
    latch1 = 1'b1;
    nv_programmed = 1'b0;
    nv_ch0 = dacl_pkg::dacl_chan_s'(17'($random(seed)));
    nv_ch1 = dacl_pkg::dacl_chan_s'(17'($random(seed)));
    cyc(5);
    note(3'h0, 32'h0);
    note(3'h1, 32'h1010);
    note(3'h2, 32'h0);
    rst_n = 1'b1;
    supply_ok = 1'b1;
    cyc(6);
    note(3'h0, {8'h00, 12'h7ff, 12'h7ff});
    note(3'h1, 32'h1111);
    note(3'h2, 32'h9);
    note(3'h5, 32'h0);
    u_host.xfer(dacl_pkg::ADDR_WIPER0, dacl_pkg::CMD_WR, 16'h0123);
    wait_ready();
    cyc(6);
    note(3'h0, {8'h00, 12'h7ff, 12'h7ff});
    $display("done: power on");
    w0 = 12'($random(seed));
    w1 = 12'($random(seed));
    wr(dacl_pkg::ADDR_WIPER0, {4'h0, w0});
    wr(dacl_pkg::ADDR_WIPER1, {4'h0, w1});
    note(3'h0, {8'h00, w1, w0});
    note(3'h5, {27'h0, dacl_pkg::ADDR_WIPER1});
    u_host.xfer(dacl_pkg::ADDR_WIPER0, dacl_pkg::CMD_RD, 16'h0000);
    note(3'h3, {20'h0, w0});
    note(3'h4, 32'h0);
    $display("done: wipers");
    for (int k = 0; k < 4; k++)
    begin
      vr0 = 2'(k);
      vr1 = 2'(3 - k);
      g0 = 1'b1;
      g1 = (k != 3);
      wr(dacl_pkg::ADDR_VREF, {12'h000, vr1, vr0});
      wr(dacl_pkg::ADDR_PD, {12'h000, vr1, vr0});
      wr(dacl_pkg::ADDR_GAIN, {6'h00, g1, g0, 8'h00});
      note(3'h1, {16'h0, ana_exp(vr1, vr1, g1), ana_exp(vr0, vr0, g0)});
    end
    u_host.xfer(dacl_pkg::ADDR_GAIN, dacl_pkg::CMD_RD, 16'h0000);
    note(3'h3, 32'h0180);
    $display("done: configuration");
    latch_pin = 1'b1;
    latch1 = 1'b0;
    cyc(4);
    n0 = 12'($random(seed));
    n1 = 12'($random(seed));
    wr(dacl_pkg::ADDR_WIPER0, {4'h0, n0});
    wr(dacl_pkg::ADDR_WIPER1, {4'h0, n1});
    wr(dacl_pkg::ADDR_PD, 16'h0005);
    wr(dacl_pkg::ADDR_VREF, 16'h000a);
    note(3'h0, {8'h00, w1, w0});
    note(3'h1, {16'h0, ana_exp(2'h0, 2'h0, 1'b0), ana_exp(2'h3, 2'h3, 1'b1)});
    latch_pin = 1'b0;
    latch1 = 1'b1;
    cyc(6);
    note(3'h0, {8'h00, n1, n0});
    note(3'h1, {16'h0, ana_exp(2'h2, 2'h1, 1'b0), ana_exp(2'h2, 2'h1, 1'b1)});
    wr(5'h05, 16'h0fff);
    note(3'h5, {27'h0, dacl_pkg::ADDR_VREF});
    note(3'h0, {8'h00, n1, n0});
    $display("done: latch");
    fork
      u_host.xfer(dacl_pkg::ADDR_WIPER0, dacl_pkg::CMD_WR, 16'h0abc);
      begin
        cyc(30);
        supply_ok = 1'b0;
      end
    join
    cyc(1);
    note(3'h0, 32'h0);
    note(3'h1, 32'h1010);
    note(3'h2, 32'h1);
    supply_ok = 1'b1;
    wait_ready();
    cyc(4);
    note(3'h0, {8'h00, 12'h7ff, 12'h7ff});
    note(3'h1, 32'h1111);
    note(3'h2, 32'hf);
    note(3'h5, 32'h0);
    $display("done: brown-out");
    cyc(1);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
